// File: design/error_rate_checker_map.svh
// Purpose: Constants for the bit error rate checker
// Assumes: Included by bare name from the package file only
// Notes: Widths of constants match what they are compared with
`ifndef ERROR_RATE_CHECKER_MAP_SVH
`define ERROR_RATE_CHECKER_MAP_SVH
// Supported link clock span, in Hz
`define LINK_CLK_MIN_HZ 100
`define LINK_CLK_MAX_HZ 20000000
`define SYNC_LOAD_BITS 5'h18
`define SYNC_LAST_BIT 5'h17
`define DEF_DATA_LIMIT 32'h0000_2710
`define DEF_ERROR_LIMIT 32'h0000_0064
`define MAX_LIMIT 32'hFFFF_FFFE
`define RATIO_STEPS 6'h20
`define PRBS9_STAGES 5'h09
`define PRBS11_STAGES 5'h0B
`define PRBS15_STAGES 5'h0F
`define PRBS16_STAGES 5'h10
`define PRBS20_STAGES 5'h14
`define PRBS21_STAGES 5'h15
`define PRBS23_STAGES 5'h17
`endif

// File: design/error_rate_checker_pkg.sv
// Purpose: Types shared by the bit error rate checker
// Assumes: error_rate_checker_map.svh holds the numeric constants
// Notes: None
`include "error_rate_checker_map.svh"
package error_rate_checker_pkg;
    typedef enum logic [2:0] {
        PRBS9, PRBS11, PRBS15, PRBS16, PRBS20, PRBS21, PRBS23
    } prbs_len_t;
    typedef enum logic [1:0] {MASK_OFF, MASK_HIGH, MASK_LOW} mask_mode_t;
    typedef enum logic [1:0] {
        LS_IDLE, LS_LOAD, LS_CHECK, LS_DONE
    } link_state_t;
    typedef struct packed {
        logic clk_falling;
        logic data_inverted;
        mask_mode_t qual_mode;
        logic restart_ext;
        prbs_len_t prbs_len;
        logic [31:0] data_bit_limit;
        logic [31:0] error_bit_limit;
    } cfg_t;
    typedef struct packed {
        logic [31:0] bit_count;
        logic [31:0] err_count;
    } result_t;
endpackage : error_rate_checker_pkg

// File: design/error_rate_checker.sv
// Purpose: PRBS bit error rate checker with self-synchronising generator
// Assumes: link_clk and link_data come from the device under test;
//          configuration is held still while a run is active
// Notes: Counting runs on link_clk; results cross to sys_clk when frozen
// Overview of operation
// RULE1: Works with link clock 100 Hz to 20 MHz
// RULE2: Tested device supplies data, clock, chosen sequence
// RULE3: Selectable sampling edge and data polarity
// RULE4: Seven generator lengths, chosen before start
// RULE5: Load generator from 24 bits, then compare
// RULE6: Count every bit and every mismatch
// RULE7: Sync error clears sync flag, retries; with restart_ext set the code goes to LS_IDLE and waits for start instead
// RULE8: Run ends at programmed data limit
// RULE9: Run ends at programmed error limit
// RULE10: Stop request ends the run at once
// RULE11: Error ratio equals errors over bits
// RULE12: Reset restores the default configuration
// RULE13: Terminated flag high after limit or stop
// RULE14: Clock activity flag set by clock edges
// RULE15: Data activity flag needs clocked data change
// RULE16: Qualifier level gates which bits count
// RULE17: Start clears counters and flags, resynchronises
module error_rate_checker
    import error_rate_checker_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cfg_write,
    input wire cfg_t cfg_in,
    input wire logic start,
    input wire logic stop,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_qual,
    output cfg_t cfg_out,
    output logic busy,
    output result_t result,
    output logic [31:0] error_ratio,
    output logic ratio_valid,
    output logic terminated,
    output logic clock_active,
    output logic data_active,
    output logic synchronised
);
    function automatic logic prbs_fb(input logic [22:0] s,
                                     input prbs_len_t t);
        case (t)
            PRBS11: prbs_fb = s[10] ^ s[8];
            PRBS15: prbs_fb = s[14] ^ s[13];
            PRBS16: prbs_fb = s[15] ^ s[13] ^ s[12] ^ s[10];
            PRBS20: prbs_fb = s[19] ^ s[16];
            PRBS21: prbs_fb = s[20] ^ s[18];
            PRBS23: prbs_fb = s[22] ^ s[17];
            default: prbs_fb = s[8] ^ s[4];
        endcase
    endfunction : prbs_fb

    function automatic logic [4:0] prbs_stages(input prbs_len_t t);
        case (t)
            PRBS11: prbs_stages = `PRBS11_STAGES;
            PRBS15: prbs_stages = `PRBS15_STAGES;
            PRBS16: prbs_stages = `PRBS16_STAGES;
            PRBS20: prbs_stages = `PRBS20_STAGES;
            PRBS21: prbs_stages = `PRBS21_STAGES;
            PRBS23: prbs_stages = `PRBS23_STAGES;
            default: prbs_stages = `PRBS9_STAGES;
        endcase
    endfunction : prbs_stages

    // System domain control
    cfg_t cfg_reg;
    logic start_tgl_reg, stop_tgl_reg, run_reg, term_reg;
    logic ack_meta_reg, ack_sync_reg, pending;
    logic done_meta_reg, done_sync_reg, done_prev_reg, snap;
    logic ctg_meta_reg, ctg_sync_reg, ctg_prev_reg, clk_seen_reg;
    logic chg_meta_reg, chg_sync_reg, sok_meta_reg, sok_sync_reg;
    result_t result_reg;
    // Link domain
    logic [1:0] lrst_reg;
    logic link_rst_n;
    cfg_t cfgl_meta_reg, cfgl_reg;
    logic st_meta_reg, st_sync_reg, st_ack_reg;
    logic sp_meta_reg, sp_sync_reg, sp_ack_reg;
    logic neg_data_reg, neg_qual_reg;
    link_state_t state_reg;
    logic [22:0] sr_reg;
    logic [4:0] load_cnt_reg;
    logic [31:0] bit_cnt_reg, err_cnt_reg;
    logic prev_bit_reg, data_chg_reg, sync_ok_reg, clk_tgl_reg, done_reg;
    logic rx_bit, rx_qual, qual_ok, exp_bit, start_evt, stop_evt;
    logic take_bit, sync_fail;
    logic [31:0] bit_cnt_next, err_cnt_next;
    // Divider
    logic [32:0] div_rem_reg, rem_sh;
    logic [31:0] div_den_reg, div_q_reg;
    logic [5:0] div_cnt_reg;
    logic q_bit, ratio_valid_reg;

    assign pending = start_tgl_reg != ack_sync_reg;
    assign snap = done_sync_reg & ~done_prev_reg & ~pending;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_reg <= '{clk_falling: 1'b0, data_inverted: 1'b0,
                         qual_mode: MASK_OFF, restart_ext: 1'b0,
                         prbs_len: PRBS9,
                         data_bit_limit: `DEF_DATA_LIMIT,
                         error_bit_limit: `DEF_ERROR_LIMIT}; // see RULE12
        end else if (cfg_write && !run_reg) begin
            // Locked during a run so the link side sees stable settings
            cfg_reg <= cfg_in; // see RULE4
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            start_tgl_reg <= 1'b0;
            stop_tgl_reg <= 1'b0;
            run_reg <= 1'b0;
            term_reg <= 1'b0;
        end else if (start) begin
            start_tgl_reg <= ~start_tgl_reg;
            run_reg <= 1'b1;
            term_reg <= 1'b0; // see RULE17
        end else if (stop && run_reg) begin
            stop_tgl_reg <= ~stop_tgl_reg;
            run_reg <= 1'b0;
            term_reg <= 1'b1; // see RULE10
        end else if (snap && run_reg) begin
            run_reg <= 1'b0;
            term_reg <= 1'b1; // see RULE13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {ack_meta_reg, ack_sync_reg} <= 2'h0;
            {done_meta_reg, done_sync_reg, done_prev_reg} <= 3'h0;
            {ctg_meta_reg, ctg_sync_reg, ctg_prev_reg} <= 3'h0;
            {chg_meta_reg, chg_sync_reg} <= 2'h0;
            {sok_meta_reg, sok_sync_reg} <= 2'h0;
        end else begin
            {ack_sync_reg, ack_meta_reg} <= {ack_meta_reg, st_ack_reg};
            {done_sync_reg, done_meta_reg} <= {done_meta_reg, done_reg};
            done_prev_reg <= done_sync_reg;
            {ctg_sync_reg, ctg_meta_reg} <= {ctg_meta_reg, clk_tgl_reg};
            ctg_prev_reg <= ctg_sync_reg;
            {chg_sync_reg, chg_meta_reg} <= {chg_meta_reg, data_chg_reg};
            {sok_sync_reg, sok_meta_reg} <= {sok_meta_reg, sync_ok_reg};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || start) begin
            clk_seen_reg <= 1'b0; // see RULE17
        end else if (!pending && ctg_sync_reg != ctg_prev_reg) begin
            clk_seen_reg <= 1'b1; // see RULE14
        end
    end

    // Counts are frozen in the link domain before done is seen here
    always_ff @(posedge sys_clk) begin
        if (!rst_n || start) begin
            result_reg <= '0;
        end else if (snap) begin
            result_reg <= '{bit_count: bit_cnt_reg, err_count: err_cnt_reg};
        end
    end

    assign rem_sh = {div_rem_reg[31:0], 1'b0};
    assign q_bit = rem_sh >= {1'b0, div_den_reg};

    always_ff @(posedge sys_clk) begin
        if (!rst_n || start) begin
            div_rem_reg <= '0;
            div_den_reg <= '0;
            div_q_reg <= '0;
            div_cnt_reg <= '0;
            ratio_valid_reg <= 1'b0;
        end else if (snap) begin
            div_rem_reg <= {1'b0, err_cnt_reg};
            div_den_reg <= bit_cnt_reg;
            div_q_reg <= '0;
            // No bits counted gives a ratio of zero at once
            div_cnt_reg <= (bit_cnt_reg == '0) ? 6'h00 : `RATIO_STEPS;
            ratio_valid_reg <= bit_cnt_reg == '0;
        end else if (div_cnt_reg != 6'h00) begin
            div_rem_reg <= q_bit ? rem_sh - {1'b0, div_den_reg} : rem_sh;
            div_q_reg <= {div_q_reg[30:0], q_bit}; // see RULE11
            div_cnt_reg <= div_cnt_reg - 6'h01;
            ratio_valid_reg <= div_cnt_reg == 6'h01;
        end
    end

    assign cfg_out = cfg_reg;
    assign busy = run_reg;
    assign result = result_reg;
    assign error_ratio = div_q_reg;
    assign ratio_valid = ratio_valid_reg;
    assign terminated = term_reg;
    assign clock_active = clk_seen_reg;
    assign data_active = chg_sync_reg & ~pending; // see RULE15
    assign synchronised = sok_sync_reg & ~pending;

    // Link domain: reset, settings and commands cross in
    // Any link rate below sys_clk works, slow ones only take longer
    always_ff @(posedge link_clk) begin // see RULE1
        lrst_reg <= {lrst_reg[0], rst_n};
    end
    assign link_rst_n = lrst_reg[1];

    always_ff @(posedge link_clk) begin
        cfgl_meta_reg <= cfg_reg;
        cfgl_reg <= cfgl_meta_reg;
        {st_sync_reg, st_meta_reg} <= {st_meta_reg, start_tgl_reg};
        {sp_sync_reg, sp_meta_reg} <= {sp_meta_reg, stop_tgl_reg};
    end

    // Falling-edge capture, consumed at the following rising edge
    always_ff @(negedge link_clk) begin
        neg_data_reg <= link_data;
        neg_qual_reg <= link_qual;
    end

    assign rx_bit = (cfgl_reg.clk_falling ? neg_data_reg : link_data)
                    ^ cfgl_reg.data_inverted; // see RULE3
    assign rx_qual = cfgl_reg.clk_falling ? neg_qual_reg : link_qual;
    assign qual_ok = (cfgl_reg.qual_mode == MASK_OFF)
                     || (cfgl_reg.qual_mode == MASK_HIGH && rx_qual)
                     || (cfgl_reg.qual_mode == MASK_LOW && !rx_qual);
    assign exp_bit = prbs_fb(sr_reg, cfgl_reg.prbs_len);
    assign start_evt = st_sync_reg != st_ack_reg;
    assign stop_evt = sp_sync_reg != sp_ack_reg;
    assign take_bit = (state_reg == LS_LOAD || state_reg == LS_CHECK)
                      && qual_ok && !start_evt && !stop_evt; // see RULE16
    assign sync_fail = take_bit && state_reg == LS_LOAD
                       && load_cnt_reg >= prbs_stages(cfgl_reg.prbs_len)
                       && rx_bit != exp_bit;
    assign bit_cnt_next = bit_cnt_reg + 32'h0000_0001;
    assign err_cnt_next = err_cnt_reg + {31'h0, rx_bit != exp_bit};

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            clk_tgl_reg <= 1'b0;
        end else begin
            clk_tgl_reg <= ~clk_tgl_reg; // see RULE14
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            {st_ack_reg, sp_ack_reg} <= 2'h0;
            state_reg <= LS_IDLE;
            sr_reg <= '0;
            load_cnt_reg <= '0;
            {bit_cnt_reg, err_cnt_reg} <= '0;
            {prev_bit_reg, data_chg_reg, done_reg} <= 3'h0;
            sync_ok_reg <= 1'b1;
        end else if (start_evt) begin
            st_ack_reg <= st_sync_reg;
            sp_ack_reg <= sp_sync_reg;
            state_reg <= LS_LOAD; // see RULE17
            load_cnt_reg <= '0;
            {bit_cnt_reg, err_cnt_reg} <= '0;
            {data_chg_reg, done_reg} <= 2'h0;
            sync_ok_reg <= 1'b1;
        end else if (stop_evt) begin
            sp_ack_reg <= sp_sync_reg;
            state_reg <= LS_DONE; // see RULE10
            done_reg <= 1'b1;
        end else begin
            if (state_reg == LS_LOAD || state_reg == LS_CHECK) begin
                prev_bit_reg <= rx_bit;
                if (rx_bit != prev_bit_reg) begin
                    data_chg_reg <= 1'b1; // see RULE15
                end
            end
            case (state_reg)
                LS_LOAD: begin
                    if (take_bit) begin
                        sr_reg <= {sr_reg[21:0], rx_bit}; // see RULE5
                        load_cnt_reg <= load_cnt_reg + 5'h01;
                        if (sync_fail) begin
                            sync_ok_reg <= 1'b0; // see RULE7
                            load_cnt_reg <= '0;
                            if (cfgl_reg.restart_ext) begin
                                state_reg <= LS_IDLE;
                            end
                        end else if (load_cnt_reg == `SYNC_LAST_BIT) begin
                            sync_ok_reg <= 1'b1;
                            state_reg <= LS_CHECK; // see RULE5
                        end
                    end
                end
                LS_CHECK: begin
                    if (take_bit) begin
                        sr_reg <= {sr_reg[21:0], exp_bit};
                        bit_cnt_reg <= bit_cnt_next; // see RULE6
                        err_cnt_reg <= err_cnt_next; // see RULE6
                        if (bit_cnt_next == cfgl_reg.data_bit_limit
                            || err_cnt_next == cfgl_reg.error_bit_limit) begin
                            state_reg <= LS_DONE; // see RULE8
                            done_reg <= 1'b1; // see RULE9
                        end
                    end
                end
                LS_DONE: done_reg <= 1'b1;
                default: done_reg <= 1'b0;
            endcase
        end
    end

    cfg_default_a: assert property (@(posedge sys_clk) // see RULE12
        $rose(rst_n) |-> cfg_reg.data_bit_limit == `DEF_DATA_LIMIT
            && cfg_reg.error_bit_limit == `DEF_ERROR_LIMIT
            && cfg_reg.prbs_len == PRBS9 && !cfg_reg.clk_falling)
        else $error("configuration not at defaults after reset");
    cfg_locked_a: assert property (@(posedge sys_clk) // see RULE4
        disable iff (!rst_n) run_reg && cfg_write |=> $stable(cfg_reg))
        else $error("configuration changed during a run");
    start_clear_a: assert property (@(posedge sys_clk) // see RULE17
        disable iff (!rst_n) start |=> result_reg == '0 && !term_reg
            && !clk_seen_reg && !ratio_valid_reg)
        else $error("start did not clear results");
    stop_end_a: assert property (@(posedge sys_clk) // see RULE10
        disable iff (!rst_n) stop && run_reg && !start
            |=> term_reg && !run_reg)
        else $error("stop did not terminate the run");
    term_run_a: assert property (@(posedge sys_clk) // see RULE13
        disable iff (!rst_n) term_reg |-> !run_reg)
        else $error("terminated while still running");
    ratio_time_a: assert property (@(posedge sys_clk) // see RULE11
        disable iff (!rst_n || start) snap && bit_cnt_reg != '0
            |-> !ratio_valid_reg [*8] ##26 ratio_valid_reg)
        else $error("ratio not ready 33 cycles after capture");
    load_len_a: assert property (@(posedge link_clk) // see RULE5
        disable iff (!link_rst_n) state_reg == LS_CHECK
            && $past(state_reg) == LS_LOAD
            |-> $past(load_cnt_reg) == `SYNC_LAST_BIT)
        else $error("compare began before 24 loaded bits");
    count_step_a: assert property (@(posedge link_clk) // see RULE6
        disable iff (!link_rst_n) state_reg == LS_CHECK && take_bit
            |=> bit_cnt_reg == $past(bit_cnt_next)
            && err_cnt_reg == $past(err_cnt_next))
        else $error("bit or error count step wrong");
    qual_hold_a: assert property (@(posedge link_clk) // see RULE16
        disable iff (!link_rst_n) state_reg == LS_CHECK && !qual_ok
            && !start_evt |=> $stable(bit_cnt_reg))
        else $error("bit counted while qualifier inactive");
    sync_retry_a: assert property (@(posedge link_clk) // see RULE7
        disable iff (!link_rst_n) sync_fail && !cfgl_reg.restart_ext
            |=> state_reg == LS_LOAD && load_cnt_reg == '0 && !sync_ok_reg)
        else $error("sync failure did not restart loading");
    data_limit_a: assert property (@(posedge link_clk) // see RULE8
        disable iff (!link_rst_n)
        state_reg == LS_CHECK |-> bit_cnt_reg < cfgl_reg.data_bit_limit)
        else $error("data limit passed without ending");
    err_limit_a: assert property (@(posedge link_clk) // see RULE9
        disable iff (!link_rst_n)
        state_reg == LS_CHECK |-> err_cnt_reg < cfgl_reg.error_bit_limit)
        else $error("error limit passed without ending");

    sync_fail_c: cover property (@(posedge link_clk)
        disable iff (!link_rst_n) sync_fail);
    limit_end_c: cover property (@(posedge link_clk)
        disable iff (!link_rst_n)
        state_reg == LS_CHECK ##1 state_reg == LS_DONE);
    stop_run_c: cover property (@(posedge sys_clk)
        disable iff (!rst_n) stop && run_reg);
    ratio_done_c: cover property (@(posedge sys_clk)
        disable iff (!rst_n) $rose(ratio_valid_reg));
endmodule : error_rate_checker

// File: dv/prbs_source.sv
// Purpose: Tested-device model sending a PRBS stream with its bit clock
// Assumes: Sequence length and polarity follow the checker's setup
// Notes: Clock stands still while run is low; data keeps toggling then
module prbs_source
    import error_rate_checker_pkg::*;
(
    input wire logic run,
    input wire prbs_len_t len,
    input wire logic fall_edge,
    input wire logic invert,
    input wire mask_mode_t qmode,
    input wire logic flip,
    output logic link_clk,
    output logic link_data,
    output logic link_qual
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [22:0] hist;
    int seed = 81;

    function automatic logic fb(input prbs_len_t l, input logic [22:0] h);
        case (l)
            PRBS9: return h[8] ^ h[4];
            PRBS11: return h[10] ^ h[8];
            PRBS15: return h[14] ^ h[13];
            PRBS16: return h[15] ^ h[13] ^ h[12] ^ h[10];
            PRBS20: return h[19] ^ h[16];
            PRBS21: return h[20] ^ h[18];
            default: return h[22] ^ h[17];
        endcase
    endfunction : fb

    // Sequence only advances on qualified bits; others carry noise
    task automatic drive();
        logic q;
        logic b;
        q = 1'($random(seed));
        link_qual = q;
        if (qmode == MASK_OFF || q == (qmode == MASK_HIGH)) begin
            b = fb(len, hist);
            hist = {hist[21:0], b};
            link_data = b ^ invert ^ flip;
        end else begin
            link_data = 1'($random(seed));
        end
    endtask : drive

    initial begin
        link_clk = 1'b0;
        link_data = 1'b0;
        link_qual = 1'b0;
        hist = '1;
        #7;
        forever begin
            if (run) begin
                #32 link_clk = 1'b1;
                if (fall_edge) drive();
                #32 link_clk = 1'b0;
                if (!fall_edge) drive();
            end else begin
                #32 link_data = ~link_data;
            end
        end
    end
endmodule : prbs_source

// File: dv/error_rate_checker_bench.sv
// Purpose: Self-checking bench for the bit error rate checker
// Assumes: prbs_source stands in for the tested device
// Notes: Link side needs its clock running through reset
module error_rate_checker_bench
    import error_rate_checker_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst_n, cfg_write, start, stop, run, flip, sync_lost;
    cfg_t cfg_in, cfg_out, cfg, c2;
    result_t result;
    logic [31:0] error_ratio;
    logic busy, ratio_valid, terminated, clock_active, data_active;
    logic synchronised, link_clk, link_data, link_qual;
    int errors = 0;
    int total_checks = 0;
    int seed = 81;
    int lim;

    error_rate_checker i_error_rate_checker (.sys_clk, .rst_n, .cfg_write,
        .cfg_in, .start, .stop, .link_clk, .link_data, .link_qual, .cfg_out,
        .busy, .result, .error_ratio, .ratio_valid, .terminated,
        .clock_active, .data_active, .synchronised);
    prbs_source i_prbs_source (.run, .len(cfg.prbs_len),
        .fall_edge(cfg.clk_falling), .invert(cfg.data_inverted),
        .qmode(cfg.qual_mode), .flip, .link_clk, .link_data, .link_qual);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (start) begin
            sync_lost <= 1'b0;
        end else if (busy && synchronised === 1'b0) begin
            sync_lost <= 1'b1;
        end
    end

    function automatic logic [31:0] exp_ratio(input longint e, input longint b);
        if (b == 0) return 32'h0000_0000;
        if (e >= b) return 32'hFFFF_FFFF;
        return 32'((e << 32) / b);
    endfunction : exp_ratio

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic check_cfg(input cfg_t exp);
        total_checks++;
        if (cfg_out !== exp) begin
            errors++;
            $display("Error cfg_out expected %0h seen %0h", exp, cfg_out);
        end
    endtask : check_cfg

    task automatic write_cfg(input cfg_t c);
        @(negedge sys_clk);
        cfg_in = c;
        cfg_write = 1'b1;
        @(negedge sys_clk);
        cfg_write = 1'b0;
        @(negedge sys_clk);
    endtask : write_cfg

    task automatic start_run();
        @(negedge sys_clk);
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        check("busy", 64'h1, busy);
        check("terminated", 64'h0, terminated);
        check("result", 64'h0, result);
    endtask : start_run

    // Each flip lands on the bit sampled one link edge later
    task automatic flip_at(input int k);
        repeat (k) @(posedge link_clk);
        flip = 1'b1;
        @(posedge link_clk);
        flip = 1'b0;
    endtask : flip_at

    // Bit count below zero means it depends on when the run ended
    task automatic finish_run(input string name, input int n, input int e);
        int w;
        w = 0;
        while (ratio_valid !== 1'b1 && w < 20000) begin
            @(negedge sys_clk);
            w++;
        end
        run = 1'b0;
        check("ratio_valid", 64'h1, ratio_valid);
        check("terminated", 64'h1, terminated);
        check("busy", 64'h0, busy);
        if (n >= 0) check("bit_count", n, result.bit_count);
        check("err_count", e, result.err_count);
        if (n >= 0) check("ratio", exp_ratio(e, n), error_ratio);
        check("synchronised", 64'h1, synchronised);
        check("clock_active", 64'h1, clock_active);
        check("data_active", 64'h1, data_active);
        $display("Test %s done", name);
    endtask : finish_run

    task automatic complete_run();
        $display("Checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        #500000;
        errors++;
        $display("Error watchdog expired");
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        cfg_write = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        flip = 1'b0;
        run = 1'b1;
        cfg_in = '0;
        cfg = '{1'b0, 1'b0, MASK_OFF, 1'b0, PRBS9, 32'h0000_2710, 32'h0000_0064};
        // Longer than two cycles so the link side sees its reset too
        repeat (30) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (30) @(negedge sys_clk);
        run = 1'b0;
        check_cfg(cfg);
        for (int i = 0; i < 7; i++) begin
            cfg.prbs_len = prbs_len_t'(i);
            {cfg.clk_falling, cfg.data_inverted} = 2'($random(seed));
            cfg.qual_mode = mask_mode_t'($unsigned($random(seed)) % 3);
            lim = (i == 6) ? 1 : 20 + ($unsigned($random(seed)) % 64);
            cfg.data_bit_limit = 32'(lim);
            cfg.error_bit_limit = 32'hFFFF_FFFE;
            write_cfg(cfg);
            check_cfg(cfg);
            start_run();
            if (i == 0) begin
                repeat (20) @(negedge sys_clk);
                check("clock_active", 64'h0, clock_active);
                check("data_active", 64'h0, data_active);
            end
            if (i == 1) begin
                c2 = cfg;
                c2.data_bit_limit = 32'h0000_0005;
                write_cfg(c2);
                check_cfg(cfg);
            end
            run = 1'b1;
            finish_run("mode", lim, 0);
        end
        cfg = '{1'b0, 1'b0, MASK_OFF, 1'b0, PRBS15, 32'd100, 32'hFFFF_FFFE};
        write_cfg(cfg);
        start_run();
        run = 1'b1;
        flip_at(40);
        flip_at(19);
        flip_at(19);
        finish_run("errors", 100, 3);
        cfg.prbs_len = PRBS23;
        cfg.data_bit_limit = 32'd1000;
        cfg.error_bit_limit = 32'd2;
        write_cfg(cfg);
        start_run();
        run = 1'b1;
        flip_at(40);
        flip_at(9);
        flip_at(9);
        finish_run("error limit", -1, 2);
        cfg = '{1'b0, 1'b0, MASK_OFF, 1'b0, PRBS9, 32'd60, 32'hFFFF_FFFE};
        write_cfg(cfg);
        start_run();
        run = 1'b1;
        flip_at(18);
        finish_run("sync", 60, 0);
        check("sync_lost", 64'h1, sync_lost);
        cfg.prbs_len = PRBS11;
        cfg.data_bit_limit = 32'd1000;
        write_cfg(cfg);
        start_run();
        run = 1'b1;
        repeat (60) @(posedge link_clk);
        @(negedge sys_clk);
        stop = 1'b1;
        @(negedge sys_clk);
        stop = 1'b0;
        check("terminated", 64'h1, terminated);
        check("busy", 64'h0, busy);
        finish_run("stop", -1, 0);
        complete_run();
    end
endmodule : error_rate_checker_bench
